// [ocov_defines.svh]
// Purpose: Shared constants of the output contact test override block
// Assumes: 100 MHz system clock, 32-bit register port
// Notes: Offsets are byte addresses, one word each
`ifndef OCOV_DEFINES_SVH
`define OCOV_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define OCOV_CLK_MHZ 100
`define OCOV_TICK_US 1000
`define OCOV_TICK_CYCLES (`OCOV_TICK_US * `OCOV_CLK_MHZ)
`define OCOV_SUP_DROP_MS 5000
`define OCOV_SUP_DROP_TICKS ((`OCOV_SUP_DROP_MS * 1000) / `OCOV_TICK_US)

// ----------------------------------------
// Sizes
// ----------------------------------------
`define OCOV_CONTACTS 8
`define OCOV_MAX_CONTACTS 8
`define OCOV_TW 16
`define OCOV_NTMR 3
`define OCOV_TMR_DISARM 0
`define OCOV_TMR_FORCE 1
`define OCOV_TMR_SUP 2
`define OCOV_NEVT 6

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OCOV_REG_MAINT 8'h00
`define OCOV_REG_DISARM 8'h04
`define OCOV_REG_FORCE 8'h08
`define OCOV_REG_TIMEOUT 8'h0c
`define OCOV_REG_TEST 8'h10
`define OCOV_REG_STATUS 8'h14
`define OCOV_REG_IRQ_STAT 8'h18
`define OCOV_REG_IRQ_MASK 8'h1c

// ----------------------------------------
// Fields
// ----------------------------------------
`define OCOV_MAINT_SRC 1:0
`define OCOV_MAINT_PANEL 2
`define OCOV_MAINT_COMM 3
`define OCOV_MAINT_PHSET 4
`define OCOV_MAINT_ACTIVE 8
`define OCOV_DIS_CTRL 0
`define OCOV_DIS_TIMED 1
`define OCOV_DIS_CMD 2
`define OCOV_DIS_REL 3
`define OCOV_DIS_STATE 15:8
`define OCOV_FRC_TIMED 0
`define OCOV_FRC_CMD 1
`define OCOV_FRC_REL 2
`define OCOV_FRC_GRP 3
`define OCOV_FRC_GVAL 4
`define OCOV_FRC_MASK 15:8
`define OCOV_FRC_SVAL 23:16
`define OCOV_FRC_ON 24
`define OCOV_TO_DIS 15:0
`define OCOV_TO_FRC 31:16
`define OCOV_TO_RESET 32'h03e8_03e8
`define OCOV_TEST_TRIP 0
`define OCOV_TEST_SUP 1
`define OCOV_ST_OUT 7:0
`define OCOV_ST_MAINT 8
`define OCOV_ST_SUPDROP 9
`define OCOV_ST_PHASE 10
`define OCOV_ST_TRIP 11

// ----------------------------------------
// Interrupt events
// ----------------------------------------
`define OCOV_EV_SUPLOG 0
`define OCOV_EV_PHASE 1
`define OCOV_EV_DIS_EXP 2
`define OCOV_EV_FRC_EXP 3
`define OCOV_EV_REFUSE 4
`define OCOV_EV_MAINT 5

`endif

// [ocov_pkg.sv]
// Purpose: Types of the output contact test override block
// Assumes: ocov_defines.svh for numeric constants
// Notes: Types only
package ocov_pkg;

  // ----------------------------------------
  // Maintenance activation sources
  // ----------------------------------------
  typedef enum logic [1:0] {
    OCOV_SRC_PANEL,
    OCOV_SRC_COMM,
    OCOV_SRC_DI
  } ocov_src_e;

endpackage

// [ocov_timer_if.sv]
// Purpose: Link between the override core and a tick timer
// Assumes: One clock domain
// Notes: start reloads a running timer
`timescale 1ns/100ps
interface ocov_timer_if #(parameter int TW = 16);
  logic start;
  logic [TW-1:0] ticks;
  logic tick;
  logic running;
  logic expired;
  modport timer (input start, input ticks, input tick, output running, output expired);
  modport ctrl (output start, output ticks, output tick, input running, input expired);
endinterface

// [ocov_tick_timer.sv]
// Purpose: Timeout timer counting timebase ticks
// Assumes: tick is a one-cycle pulse on sys_clk
// Notes: expired pulses for one cycle at the end of a run
`timescale 1ns/100ps
module ocov_tick_timer import ocov_pkg::*; #(
  parameter int TW = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control side
  ocov_timer_if.timer tif
);

  logic [TW-1:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic exp_q, exp_d;

  // ----------------------------------------
  // Count
  // ----------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (tif.start) begin
      cnt_d = tif.ticks;
      run_d = (tif.ticks != '0);
    end else if (run_q && tif.tick) begin
      if (cnt_q <= TW'(1)) begin
        cnt_d = '0;
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q - TW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign tif.running = run_q;
  assign tif.expired = exp_q;

endmodule // ocov_tick_timer

// [ocov_contact_override.sv]
// Purpose: Disarm, force and test overrides of relay output contacts
// Assumes: Requests come from logic on sys_clk; maint_di_pin is a raw pin
// Notes: nv_maint_restore comes from non-volatile storage at power-up
//
// Behaviour
// - Refuse source change while source signal active
// - Complementary maintenance active and inactive outputs
// - Whole contact group can be disarmed
// - Disarm permanent or timed by timer
// - Zone interlock and supervision never disarmed
// - Disarm needs unlatched, no hold, control, command
// - Force permanent or timed by timer
// - Group force beats single-contact force
// - Disarmed contact ignores force
// - Force only when undisarmed and commanded
// - Manual trip force drives trip output
// - Supervision drop lasts five seconds
// - Each supervision drop logs an entry
// - Flag phase rotation mismatch with setting
// - Maintenance state restored at power-up
// - Maintenance from panel, communication or input
`timescale 1ns/100ps
`include "ocov_defines.svh"
module ocov_contact_override import ocov_pkg::*; #(
  parameter int N = `OCOV_CONTACTS,
  parameter int TICK_CYCLES = `OCOV_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Contact requests from protection logic
  input wire logic [N-1:0] contact_req,
  input wire logic [N-1:0] contact_latched,
  input wire logic [N-1:0] contact_hold_run,
  input wire logic zone_il_req,
  input wire logic sup_healthy,
  input wire logic prot_trip,
  // Maintenance and measurement
  input wire logic maint_di_pin,
  input wire logic nv_maint_restore,
  input wire logic phase_calc_rev,
  // Relay and status outputs
  output logic [N-1:0] contact_out,
  output logic zone_il_out,
  output logic supervision_contact,
  output logic trip_cmd,
  output logic maint_active,
  output logic maint_inactive,
  output logic sup_log_entry,
  output logic phase_mismatch,
  output logic irq
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (N < 1 || N > `OCOV_MAX_CONTACTS) begin : g_bad_n
    $error("contact count out of range");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("tick period too short");
  end

  localparam int TW = `OCOV_TW;
  localparam logic [TW-1:0] SUP_TICKS = TW'(`OCOV_SUP_DROP_TICKS);

  function automatic logic src_level(input ocov_src_e s, input logic pnl, input logic com, input logic di);
    case (s)
      OCOV_SRC_PANEL: src_level = pnl;
      OCOV_SRC_COMM: src_level = com;
      OCOV_SRC_DI: src_level = di;
      default: src_level = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchroniser and timebase
  // ----------------------------------------
  logic di_s1_q, di_s2_q;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h1;
    if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      di_s1_q <= 1'b0;
      di_s2_q <= 1'b0;
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      di_s1_q <= maint_di_pin;
      di_s2_q <= di_s1_q;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  ocov_timer_if #(.TW(TW)) tif [`OCOV_NTMR] ();
  logic [`OCOV_NTMR-1:0] tmr_start;
  logic [TW-1:0] tmr_ticks [`OCOV_NTMR];
  logic [`OCOV_NTMR-1:0] tmr_run, tmr_exp;

  for (genvar t = 0; t < `OCOV_NTMR; t++) begin : g_tmr
    assign tif[t].start = tmr_start[t];
    assign tif[t].ticks = tmr_ticks[t];
    assign tif[t].tick = tick_q;
    assign tmr_run[t] = tif[t].running;
    assign tmr_exp[t] = tif[t].expired;
    ocov_tick_timer #(.TW(TW)) u_tmr (
      .sys_clk(sys_clk),
      .rst(rst),
      .tif(tif[t])
    );
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  ocov_src_e src_q, src_d;
  logic panel_q, panel_d, comm_q, comm_d, phset_q, phset_d;
  logic maint_q, maint_d, lvl_prev_q, lvl_prev_d, restored_q, restored_d;
  logic dis_ctrl_q, dis_ctrl_d, dis_timed_q, dis_timed_d, dis_on_q, dis_on_d;
  logic frc_timed_q, frc_timed_d, frc_on_q, frc_on_d, grp_q, grp_d, gval_q, gval_d;
  logic [N-1:0] smask_q, smask_d, sval_q, sval_d;
  logic [31:0] tout_q, tout_d;
  logic ftrip_q, ftrip_d, log_q, log_d, phase_q, phase_d;
  logic [`OCOV_NEVT-1:0] ist_q, ist_d, imask_q, imask_d, evt;
  logic [31:0] rdata_q, rdata_d;
  logic [N-1:0] disarmed_q, disarmed_d, out_q, out_d;
  logic wr_maint, wr_dis, wr_frc, wr_test, lvl_cur, lvl_new;
  ocov_src_e src_req;

  assign wr_maint = reg_wr && reg_addr == `OCOV_REG_MAINT;
  assign wr_dis = reg_wr && reg_addr == `OCOV_REG_DISARM;
  assign wr_frc = reg_wr && reg_addr == `OCOV_REG_FORCE;
  assign wr_test = reg_wr && reg_addr == `OCOV_REG_TEST;
  assign src_req = ocov_src_e'(reg_wdata[`OCOV_MAINT_SRC]);
  assign lvl_cur = src_level(src_q, panel_q, comm_q, di_s2_q);
  // A source switch re-arms the edge detector on the new source, so switching alone never toggles the mode
  assign lvl_new = src_level(src_d, panel_q, comm_q, di_s2_q);

  assign tmr_start[`OCOV_TMR_DISARM] = wr_dis && reg_wdata[`OCOV_DIS_CMD] && reg_wdata[`OCOV_DIS_TIMED];
  assign tmr_start[`OCOV_TMR_FORCE] = wr_frc && reg_wdata[`OCOV_FRC_CMD] && reg_wdata[`OCOV_FRC_TIMED];
  assign tmr_start[`OCOV_TMR_SUP] = wr_test && reg_wdata[`OCOV_TEST_SUP];
  assign tmr_ticks[`OCOV_TMR_DISARM] = tout_q[`OCOV_TO_DIS];
  assign tmr_ticks[`OCOV_TMR_FORCE] = tout_q[`OCOV_TO_FRC];
  assign tmr_ticks[`OCOV_TMR_SUP] = SUP_TICKS;

  always_comb begin
    src_d = src_q;
    panel_d = panel_q;
    comm_d = comm_q;
    phset_d = phset_q;
    dis_ctrl_d = dis_ctrl_q;
    dis_timed_d = dis_timed_q;
    frc_timed_d = frc_timed_q;
    grp_d = grp_q;
    gval_d = gval_q;
    smask_d = smask_q;
    sval_d = sval_q;
    tout_d = tout_q;
    ftrip_d = ftrip_q;
    imask_d = imask_q;
    evt = '0;
    if (wr_maint) begin
      panel_d = reg_wdata[`OCOV_MAINT_PANEL];
      comm_d = reg_wdata[`OCOV_MAINT_COMM];
      phset_d = reg_wdata[`OCOV_MAINT_PHSET];
      if (src_req != src_q && (lvl_cur || src_req > OCOV_SRC_DI)) begin
        evt[`OCOV_EV_REFUSE] = 1'b1;
      end else begin
        src_d = src_req;
      end
    end
    if (wr_dis) begin
      dis_ctrl_d = reg_wdata[`OCOV_DIS_CTRL];
      dis_timed_d = reg_wdata[`OCOV_DIS_TIMED];
    end
    if (wr_frc) begin
      frc_timed_d = reg_wdata[`OCOV_FRC_TIMED];
      grp_d = reg_wdata[`OCOV_FRC_GRP];
      gval_d = reg_wdata[`OCOV_FRC_GVAL];
      smask_d = reg_wdata[8 +: N];
      sval_d = reg_wdata[16 +: N];
    end
    if (reg_wr && reg_addr == `OCOV_REG_TIMEOUT) begin
      tout_d = reg_wdata;
    end
    if (wr_test) begin
      ftrip_d = reg_wdata[`OCOV_TEST_TRIP];
    end
    if (reg_wr && reg_addr == `OCOV_REG_IRQ_MASK) begin
      imask_d = reg_wdata[`OCOV_NEVT-1:0];
    end
    // timed disarm ends at expiry, permanent holds
    dis_on_d = dis_on_q;
    if (wr_dis && reg_wdata[`OCOV_DIS_REL]) begin
      dis_on_d = 1'b0;
    end else if (wr_dis && reg_wdata[`OCOV_DIS_CMD]) begin
      dis_on_d = 1'b1;
    end else if (dis_timed_q && tmr_exp[`OCOV_TMR_DISARM]) begin
      dis_on_d = 1'b0;
    end
    // timed force ends at expiry, permanent holds
    frc_on_d = frc_on_q;
    if (wr_frc && reg_wdata[`OCOV_FRC_REL]) begin
      frc_on_d = 1'b0;
    end else if (wr_frc && reg_wdata[`OCOV_FRC_CMD]) begin
      frc_on_d = 1'b1;
    end else if (frc_timed_q && tmr_exp[`OCOV_TMR_FORCE]) begin
      frc_on_d = 1'b0;
    end
    evt[`OCOV_EV_DIS_EXP] = dis_timed_q && dis_on_q && tmr_exp[`OCOV_TMR_DISARM];
    evt[`OCOV_EV_FRC_EXP] = frc_timed_q && frc_on_q && tmr_exp[`OCOV_TMR_FORCE];
    log_d = tmr_start[`OCOV_TMR_SUP];
    evt[`OCOV_EV_SUPLOG] = log_d;
    phase_d = phase_calc_rev != phset_q;
    evt[`OCOV_EV_PHASE] = phase_d && !phase_q;
    // restore stored state once after reset
    restored_d = 1'b1;
    lvl_prev_d = lvl_new;
    maint_d = maint_q;
    if (!restored_q) begin
      maint_d = nv_maint_restore;
    end else if (lvl_cur != lvl_prev_q) begin
      maint_d = lvl_cur;
    end
    evt[`OCOV_EV_MAINT] = restored_q && maint_d != maint_q;
    // Read clears status, but a new event in the same cycle survives
    ist_d = ist_q;
    if (reg_rd && reg_addr == `OCOV_REG_IRQ_STAT) begin
      ist_d = '0;
    end
    ist_d = ist_d | evt;
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        `OCOV_REG_MAINT: rdata_d = {23'h0, maint_q, 3'h0, phset_q, comm_q, panel_q, src_q};
        `OCOV_REG_DISARM: rdata_d = {16'h0, 8'(disarmed_q), 5'h0, dis_on_q, dis_timed_q, dis_ctrl_q};
        `OCOV_REG_FORCE: rdata_d = {7'h0, frc_on_q, 8'(sval_q), 8'(smask_q), 3'h0, gval_q, grp_q, 2'h0,
                                    frc_timed_q};
        `OCOV_REG_TIMEOUT: rdata_d = tout_q;
        `OCOV_REG_TEST: rdata_d = {31'h0, ftrip_q};
        `OCOV_REG_STATUS: rdata_d = {20'h0, trip_cmd, phase_q, tmr_run[`OCOV_TMR_SUP], maint_q, 8'(out_q)};
        `OCOV_REG_IRQ_STAT: rdata_d = 32'(ist_q);
        `OCOV_REG_IRQ_MASK: rdata_d = 32'(imask_q);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_q <= OCOV_SRC_PANEL;
      panel_q <= 1'b0;
      comm_q <= 1'b0;
      phset_q <= 1'b0;
      maint_q <= 1'b0;
      lvl_prev_q <= 1'b0;
      restored_q <= 1'b0;
      dis_ctrl_q <= 1'b0;
      dis_timed_q <= 1'b0;
      dis_on_q <= 1'b0;
      frc_timed_q <= 1'b0;
      frc_on_q <= 1'b0;
      grp_q <= 1'b0;
      gval_q <= 1'b0;
      smask_q <= '0;
      sval_q <= '0;
      tout_q <= `OCOV_TO_RESET;
      ftrip_q <= 1'b0;
      log_q <= 1'b0;
      phase_q <= 1'b0;
      ist_q <= '0;
      imask_q <= '0;
      rdata_q <= '0;
    end else begin
      src_q <= src_d;
      panel_q <= panel_d;
      comm_q <= comm_d;
      phset_q <= phset_d;
      maint_q <= maint_d;
      lvl_prev_q <= lvl_prev_d;
      restored_q <= restored_d;
      dis_ctrl_q <= dis_ctrl_d;
      dis_timed_q <= dis_timed_d;
      dis_on_q <= dis_on_d;
      frc_timed_q <= frc_timed_d;
      frc_on_q <= frc_on_d;
      grp_q <= grp_d;
      gval_q <= gval_d;
      smask_q <= smask_d;
      sval_q <= sval_d;
      tout_q <= tout_d;
      ftrip_q <= ftrip_d;
      log_q <= log_d;
      phase_q <= phase_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Contact gating
  // ----------------------------------------
  logic zone_q, zone_d, sup_q, sup_d, trip_q, trip_d;

  for (genvar i = 0; i < N; i++) begin : g_contact
    always_comb begin
      // entry needs all four conditions; once in, stays while commanded and control is set
      disarmed_d[i] = dis_on_q && dis_ctrl_q &&
                      (disarmed_q[i] || (!contact_latched[i] && !contact_hold_run[i]));
      // disarmed contact is frozen, no switching
      if (disarmed_q[i]) begin
        out_d[i] = out_q[i];
      // force only on undisarmed, commanded contact
      end else if (frc_on_q && (grp_q || smask_q[i])) begin
        out_d[i] = grp_q ? gval_q : sval_q[i];
      end else begin
        out_d[i] = contact_req[i];
      end
    end
  end

  always_comb begin
    // zone interlock and supervision bypass disarm
    zone_d = zone_il_req;
    sup_d = sup_healthy && !tmr_run[`OCOV_TMR_SUP];
    // manual trip acts like a protection trip
    trip_d = prot_trip || ftrip_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      disarmed_q <= '0;
      out_q <= '0;
      zone_q <= 1'b0;
      sup_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      disarmed_q <= disarmed_d;
      out_q <= out_d;
      zone_q <= zone_d;
      sup_q <= sup_d;
      trip_q <= trip_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign contact_out = out_q;
  assign zone_il_out = zone_q;
  assign supervision_contact = sup_q;
  assign trip_cmd = trip_q;
  assign maint_active = maint_q;
  assign maint_inactive = !maint_q;
  assign sup_log_entry = log_q;
  assign phase_mismatch = phase_q;
  assign reg_rdata = rdata_q;
  assign irq = |(ist_q & imask_q);

endmodule // ocov_contact_override

// [ocov_override_assertions.sv]
// Purpose: Port-level checks of the contact override block
// Assumes: One clock, rst asynchronous and active high
// Notes: Outputs that depend on register contents are judged by the bench
`timescale 1ns/100ps
module ocov_override_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_rdata,
  // Watched pins
  input wire logic zone_il_req,
  input wire logic zone_il_out,
  input wire logic sup_healthy,
  input wire logic supervision_contact,
  input wire logic prot_trip,
  input wire logic trip_cmd,
  input wire logic maint_active,
  input wire logic maint_inactive,
  input wire logic nv_maint_restore,
  input wire logic sup_log_entry,
  input wire logic phase_calc_rev,
  input wire logic phase_mismatch,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  maint_flags_a: assert property (maint_active != maint_inactive)
    else $error("maintenance flags not complementary");
  nv_restore_a: assert property ($past(rst) && !rst |=> maint_active == $past(nv_maint_restore))
    else $error("maintenance state not restored after reset");
  zone_pass_a: assert property (!$past(rst) |-> zone_il_out == $past(zone_il_req))
    else $error("zone interlock output does not follow request");
  sup_follow_a: assert property (!$past(rst) && !$past(sup_healthy) |-> !supervision_contact)
    else $error("supervision contact held while unhealthy");
  trip_follow_a: assert property (!$past(rst) && $past(prot_trip) |-> trip_cmd)
    else $error("protection trip not passed to trip command");
  drop_start_a: assert property (sup_log_entry |=> !supervision_contact [*8])
    else $error("supervision contact not dropped after log entry");
  log_pulse_a: assert property (sup_log_entry |=> !sup_log_entry)
    else $error("log entry pulse longer than one cycle");
  phase_track_a: assert property (!$past(rst) && $changed(phase_calc_rev) && !reg_wr && !$past(reg_wr)
    |=> $changed(phase_mismatch))
    else $error("phase flag did not follow computed rotation");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");

  cover property (sup_log_entry);
  cover property ($rose(maint_active));
  cover property ($rose(irq));
  cover property ($rose(trip_cmd));
endmodule // ocov_override_checker

bind ocov_contact_override ocov_override_checker i_ocov_override_checker (
  .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .zone_il_req(zone_il_req), .zone_il_out(zone_il_out), .sup_healthy(sup_healthy),
  .supervision_contact(supervision_contact), .prot_trip(prot_trip), .trip_cmd(trip_cmd),
  .maint_active(maint_active), .maint_inactive(maint_inactive), .nv_maint_restore(nv_maint_restore),
  .sup_log_entry(sup_log_entry), .phase_calc_rev(phase_calc_rev), .phase_mismatch(phase_mismatch), .irq(irq));

// [ocov_relay_model.sv]
// Purpose: Relay output contacts as seen from the override block
// Assumes: A relay keeps a release hold after its drive drops
// Notes: Hold length is a plain parameter
`timescale 1ns/100ps
module ocov_relay_model #(
  parameter int N = 8,
  parameter int HOLD = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Drives and hold timers
  input wire logic [N-1:0] contact_out,
  output logic [N-1:0] contact_hold_run
);
  logic [N-1:0] prev_q;
  int cnt_q [N];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
      for (int i = 0; i < N; i++) cnt_q[i] <= 0;
    end else begin
      prev_q <= contact_out;
      // Every drop restarts the hold, so a disarm can be delayed by it
      for (int i = 0; i < N; i++) cnt_q[i] <= (prev_q[i] && !contact_out[i]) ? HOLD : (cnt_q[i] > 0 ? cnt_q[i] - 1 : 0);
    end
  end
  always_comb for (int i = 0; i < N; i++) contact_hold_run[i] = cnt_q[i] != 0;
endmodule // ocov_relay_model

// [ocov_contact_override_tb.sv]
// Purpose: Self-checking bench of the contact override block
// Assumes: Fast tick of 4 cycles; relay model supplies hold timers
// Notes: Contact patterns drawn at random from a fixed seed
`timescale 1ns/100ps
`include "ocov_defines.svh"
module ocov_contact_override_tb import ocov_pkg::*;;
  localparam int TICK = 4;
  localparam int DROP = `OCOV_SUP_DROP_TICKS * TICK;
  logic sys_clk = 0;
  logic rst, reg_wr, reg_rd, zone_il_req, sup_healthy, prot_trip, maint_di_pin, nv_maint_restore, phase_calc_rev;
  logic [7:0] reg_addr, contact_req, contact_latched, contact_hold_run, contact_out;
  logic [31:0] reg_wdata, reg_rdata;
  logic zone_il_out, supervision_contact, trip_cmd, maint_active, maint_inactive, sup_log_entry, phase_mismatch, irq;
  int fails = 0, checked = 0, logs = 0, low = 0;

  ocov_contact_override #(.N(8), .TICK_CYCLES(TICK)) i_ocov_contact_override (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .contact_req(contact_req), .contact_latched(contact_latched),
    .contact_hold_run(contact_hold_run), .zone_il_req(zone_il_req), .sup_healthy(sup_healthy),
    .prot_trip(prot_trip), .maint_di_pin(maint_di_pin), .nv_maint_restore(nv_maint_restore),
    .phase_calc_rev(phase_calc_rev), .contact_out(contact_out), .zone_il_out(zone_il_out),
    .supervision_contact(supervision_contact), .trip_cmd(trip_cmd), .maint_active(maint_active),
    .maint_inactive(maint_inactive), .sup_log_entry(sup_log_entry), .phase_mismatch(phase_mismatch), .irq(irq));
  ocov_relay_model #(.N(8), .HOLD(6)) i_ocov_relay_model (
    .sys_clk(sys_clk), .rst(rst), .contact_out(contact_out), .contact_hold_run(contact_hold_run));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (sup_log_entry === 1'b1) logs++;
    if (supervision_contact === 1'b0) low++;
  end

  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1;
    d = reg_rdata;
  endtask
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Disarmed contacts keep their frozen value; group force beats the single mask
  function automatic logic [7:0] exp_out(logic [7:0] req, frz, dis, logic fon, grp, gv, logic [7:0] m, sv);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = dis[i] ? frz[i] : (fon && (grp || m[i])) ? (grp ? gv : sv[i]) : req[i];
    return r;
  endfunction

  // Limit is about twice the planned run, mostly the supervision drop
  initial begin
    #400000;
    fails++;
    results;
  end

  initial begin
    logic [31:0] d;
    logic [7:0] req, req2, lat, dis, m, sv;
    int l0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, contact_req, contact_latched} = '0;
    {zone_il_req, prot_trip, maint_di_pin, phase_calc_rev} = '0;
    sup_healthy = 1;
    nv_maint_restore = 1;
    rst = 1;
    d = $urandom(32'had1d8092);
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    wt(2);
    chk("maint restored", maint_active, 1);
    chk("maint inactive", maint_inactive, 0);
    rd(`OCOV_REG_TIMEOUT, d);
    chk("timeout reset", d, `OCOV_TO_RESET);
    rd(8'h20, d);
    chk("unmapped read", d, 0);
    wr(`OCOV_REG_MAINT, 32'h4);
    wr(`OCOV_REG_MAINT, 32'h0);
    wt(2);
    chk("panel off", maint_active, 0);
    chk("inactive flag", maint_inactive, 1);
    wr(`OCOV_REG_MAINT, 32'h1);
    wr(`OCOV_REG_MAINT, 32'h9);
    wt(2);
    chk("comm on", maint_active, 1);
    wr(`OCOV_REG_MAINT, 32'h1);
    wr(`OCOV_REG_MAINT, 32'h2);
    @(posedge sys_clk) maint_di_pin <= 1;
    wt(5);
    chk("input on", maint_active, 1);
    wr(`OCOV_REG_MAINT, 32'h0);
    rd(`OCOV_REG_MAINT, d);
    chk("source kept", d[1:0], 2);
    rd(`OCOV_REG_IRQ_STAT, d);
    chk("refuse event", d[`OCOV_EV_REFUSE], 1);
    @(posedge sys_clk) maint_di_pin <= 0;
    wt(5);
    chk("input off", maint_active, 0);
    wr(`OCOV_REG_MAINT, 32'h0);
    wr(`OCOV_REG_IRQ_MASK, 32'h2);
    @(posedge sys_clk) phase_calc_rev <= 1;
    wt(3);
    chk("phase flag", phase_mismatch, 1);
    chk("irq raised", irq, 1);
    rd(`OCOV_REG_IRQ_STAT, d);
    chk("phase event", d[`OCOV_EV_PHASE], 1);
    chk("irq cleared", irq, 0);
    wr(`OCOV_REG_MAINT, 32'h10);
    wt(2);
    chk("phase match", phase_mismatch, 0);
    wr(`OCOV_REG_TEST, 32'h1);
    wt(2);
    chk("forced trip", trip_cmd, 1);
    rd(`OCOV_REG_STATUS, d);
    chk("trip status", d[`OCOV_ST_TRIP], 1);
    wr(`OCOV_REG_TEST, 32'h0);
    wt(2);
    chk("trip off", trip_cmd, 0);
    @(posedge sys_clk) prot_trip <= 1;
    wt(2);
    chk("prot trip", trip_cmd, 1);
    @(posedge sys_clk) prot_trip <= 0;
    wr(`OCOV_REG_TIMEOUT, 32'h0005_000a);
    for (int it = 0; it < 4; it++) begin
      req = $urandom;
      lat = $urandom;
      dis = ~lat;
      m = $urandom;
      sv = $urandom;
      @(posedge sys_clk);
      contact_req <= req;
      contact_latched <= lat;
      wt(12);
      wr(`OCOV_REG_DISARM, it[0] ? 32'h7 : 32'h5);
      wt(4);
      rd(`OCOV_REG_DISARM, d);
      chk("disarm set", d[15:8], dis);
      req2 = ~req;
      @(posedge sys_clk);
      contact_req <= req2;
      zone_il_req <= it[1];
      sup_healthy <= 0;
      wt(2);
      chk("frozen", contact_out, exp_out(req2, req, dis, 0, 0, 0, 0, 0));
      chk("zone", zone_il_out, it[1]);
      chk("sup live", supervision_contact, 0);
      @(posedge sys_clk) sup_healthy <= 1;
      wr(`OCOV_REG_FORCE, {8'h0, sv, m, 3'h0, 1'b1, it[1], 3'h2});
      wt(3);
      chk("force vs disarm", contact_out, exp_out(req2, req, dis, 1, it[1], 1, m, sv));
      wt(50);
      if (!it[0]) begin
        chk("permanent", contact_out, exp_out(req2, req, dis, 1, it[1], 1, m, sv));
        wr(`OCOV_REG_DISARM, 32'h8);
      end
      wt(3);
      chk("disarm gone", contact_out, exp_out(req2, req, 0, 1, it[1], 1, m, sv));
      wr(`OCOV_REG_FORCE, {27'h0, it[0], 4'hb});
      wt(3);
      chk("timed force", contact_out, {8{it[0]}});
      wt(30);
      chk("force expired", contact_out, req2);
    end
    rd(`OCOV_REG_IRQ_STAT, d);
    chk("expiry events", d[5:0], 6'h0c);
    l0 = low;
    wr(`OCOV_REG_TEST, 32'h2);
    wt(DROP + 50);
    chk("drop log", logs, 1);
    chk("drop length", (low - l0 >= DROP - TICK) && (low - l0 <= DROP + TICK), 1);
    results;
  end
endmodule // ocov_contact_override_tb
